// *** sdac_backend.sv ***
`timescale 1ns/10ps
// Behaviour
// - Both burnout currents follow the single burnout_enable bit together.
// - burnout_enable low turns both burnout currents off.
// - Excitation sources go one per pin or both onto one chosen pin.
// - Reference detector low or open sets ref_missing_flag.
// - Conversion results read all ones while the reference is missing.
// - Missing reference during calibration blocks the write, sets cal error.
// - Each converter filters its bitstream with a sinc3 set by decimation_word.
// - decimation_word resets to its default, just under 20 Hz.
// - Inputs are chopped; each output averages with the previous one.
// - First result after a start appears after two filter outputs.
// - Four calibration modes: internal/system zero-scale and full-scale.
// - Reset loads factory offset and gain coefficients for both converters.
// - Calibration overwrites coefficients only of enabled converters.
// - Zero-scale result goes to offset, full-scale result to gain.
// - Internal modes connect the sources; system modes need external inputs.
// - Calibration always runs at the slowest filter rate.
// - Correction subtracts the offset, then multiplies by the gain.
// - Calibration end sets the converter's conversion ready bit.
// - Unipolar gives straight binary; bipolar gives offset binary.
// - Polarity bits choose output coding for each converter only.
module sdac_backend (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [1:0]  mod_bit,
  input  wire logic [1:0]  mod_valid,
  output logic             mod_hold,
  output logic [1:0]       chop_invert,
  input  wire logic [1:0]  input_change,
  input  wire logic        burnout_enable,
  output logic             burnout_source_on,
  output logic             burnout_sink_on,
  input  wire logic [3:0]  current_source_control,
  output logic [1:0]       excitation_out_a,
  output logic [1:0]       excitation_out_b,
  input  wire logic        ref_detect_low,
  output logic             ref_missing_flag,
  input  wire logic        mode_write,
  input  wire logic [2:0]  mode_wdata,
  input  wire logic [1:0]  enable_wdata,
  output logic [2:0]       adc_mode,
  output logic [1:0]       adc_enable,
  input  wire logic        decimation_write,
  input  wire logic [7:0]  decimation_wdata,
  output logic [7:0]       decimation_word,
  input  wire logic        unipolar_primary,
  input  wire logic        unipolar_aux,
  input  wire logic [15:0] factory_offset_primary,
  input  wire logic [15:0] factory_offset_aux,
  input  wire logic [15:0] factory_gain_primary,
  input  wire logic [15:0] factory_gain_aux,
  output logic [15:0]      offset_primary,
  output logic [15:0]      offset_aux,
  output logic [15:0]      gain_primary,
  output logic [15:0]      gain_aux,
  output logic             cal_connect_zero,
  output logic             cal_connect_full,
  input  wire logic [1:0]  ready_clear,
  output logic             conversion_ready_primary,
  output logic             conversion_ready_aux,
  output logic             cal_error_primary,
  output logic             cal_error_aux,
  output logic [15:0]      result_primary,
  output logic [15:0]      result_aux,
  output logic             result_valid,
  input  wire logic        result_ready,
  output logic [16:0]      result_data
);
  localparam int AW = sdac_pkg::ACC_W;

  sdac_pkg::sdac_state_t state, next_state;
  logic [2:0]  mode, next_mode;
  logic [1:0]  en_mask, next_en_mask;
  logic [7:0]  dec_word, next_dec_word;
  logic [2:0]  cal_kind, next_cal_kind;
  logic [1:0]  cal_pend, next_cal_pend;
  logic [1:0]  cal_ref_bad, next_cal_ref_bad;
  logic [1:0]  rdy, next_rdy;
  logic [1:0]  err, next_err;
  logic        ref_flag, next_ref_flag;
  logic        conn_zero, next_conn_zero;
  logic        conn_full, next_conn_full;
  logic        bo_on, next_bo_on;
  logic [1:0]  exc_a, next_exc_a;
  logic [1:0]  exc_b, next_exc_b;
  logic [15:0] off_c [2];
  logic [15:0] gain_c [2];
  logic [15:0] res_q [2];
  logic [15:0] pend_word [2];
  logic [15:0] next_off_c [2];
  logic [15:0] next_gain_c [2];
  logic [15:0] next_res_q [2];
  logic [15:0] next_pend_word [2];
  logic signed [AW-1:0] prev [2];
  logic signed [AW-1:0] next_prev [2];
  logic signed [AW-1:0] f_data [2];
  logic signed [AW-1:0] s_val;
  logic signed [AW:0]   sum;
  logic signed [15:0]   raw;
  logic [1:0]  chop, next_chop;
  logic [1:0]  seen, next_seen;
  logic [1:0]  pend, next_pend;
  logic [1:0]  f_valid;
  logic [1:0]  run;
  logic [1:0]  restart;
  logic [1:0]  uni;
  logic [7:0]  dec_eff;
  logic [sdac_pkg::RAT_W-1:0] ratio;
  logic        fifo_in_ready;
  logic        push_valid;
  logic        push_sel;
  logic [16:0] push_data;
  logic [2:0]  exc_sum;

  // Offset, gain, coding and reference substitution of one filter word
  function automatic logic [15:0] sdac_to_code(
    input logic signed [15:0] raw_in,
    input logic        [15:0] off_in,
    input logic        [15:0] gain_in,
    input logic               uni_in,
    input logic               miss_in
  );
    logic signed [16:0] diff;
    logic signed [33:0] prod;
    logic        [18:0] scl;
    logic        [15:0] sat;
    diff = $signed({raw_in[15], raw_in}) - $signed({off_in[15], off_in});
    prod = diff * $signed({1'b0, gain_in});
    scl  = prod[sdac_pkg::GAIN_FRAC+18:sdac_pkg::GAIN_FRAC];
    if (scl[18:15] == 4'h0 || scl[18:15] == 4'hF) begin
      sat = scl[15:0];
    end else begin
      sat = scl[18] ? sdac_pkg::SAT_MIN : sdac_pkg::SAT_MAX;
    end
    if (miss_in) begin
      sdac_to_code = sdac_pkg::CODE_ALL_ONES;
    end else if (uni_in) begin
      // Negative readings clip at zero in straight binary
      sdac_to_code = sat[15] ? sdac_pkg::CODE_ZERO : {sat[14:0], 1'b0};
    end else begin
      sdac_to_code = {~sat[15], sat[14:0]};
    end
  endfunction

  always_comb begin
    uni[0] = unipolar_primary;
    uni[1] = unipolar_aux;
    dec_eff = (state == sdac_pkg::SDAC_CAL) ? sdac_pkg::DEC_CAL
                                            : dec_word;
    ratio = {3'h0, dec_eff} << sdac_pkg::DEC_SHIFT;
    for (int i = 0; i < 2; i++) begin
      run[i] = (state == sdac_pkg::SDAC_CAL) ? cal_pend[i]
             : (mode == sdac_pkg::MODE_CONT) && en_mask[i];
      restart[i] = mode_write | decimation_write | input_change[i];
    end
    push_valid = |pend;
    push_sel   = ~pend[0];
    push_data  = {push_sel, pend_word[push_sel]};
    mod_hold   = ~fifo_in_ready;
  end

  // Filter output stalls while its word waits or the FIFO is full
  generate
    for (genvar g = 0; g < 2; g++) begin : g_conv
      sdac_sinc3 u_sinc (
        .core_clk   (core_clk),
        .rst        (rst),
        .restart    (restart[g]),
        .sample_en  (mod_valid[g] & run[g] & ~pend[g] & fifo_in_ready),
        .sample_bit (mod_bit[g]),
        .ratio      (ratio),
        .out_valid  (f_valid[g]),
        .out_data   (f_data[g])
      );
    end
  endgenerate

  sdac_fifo #(
    .WIDTH (sdac_pkg::FIFO_W),
    .DEPTH (sdac_pkg::FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .rst       (rst),
    .in_valid  (push_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (push_data),
    .out_valid (result_valid),
    .out_ready (result_ready),
    .out_data  (result_data)
  );

  always_comb begin
    next_state       = state;
    next_mode        = mode;
    next_en_mask     = en_mask;
    next_dec_word    = dec_word;
    next_cal_kind    = cal_kind;
    next_cal_pend    = cal_pend;
    next_cal_ref_bad = cal_ref_bad;
    next_err         = err;
    next_chop        = chop;
    next_seen        = seen;
    next_pend        = pend;
    next_off_c       = off_c;
    next_gain_c      = gain_c;
    next_res_q       = res_q;
    next_pend_word   = pend_word;
    next_prev        = prev;
    s_val            = '0;
    sum              = '0;
    raw              = '0;
    next_ref_flag = ref_detect_low;
    next_bo_on    = burnout_enable;
    exc_sum = {2'h0, current_source_control[sdac_pkg::CSC_SRC1]} +
              {2'h0, current_source_control[sdac_pkg::CSC_SRC2]};
    if (current_source_control[sdac_pkg::CSC_COMBINE]) begin
      next_exc_a = current_source_control[sdac_pkg::CSC_TO_B] ? 2'h0
                                                              : exc_sum[1:0];
      next_exc_b = current_source_control[sdac_pkg::CSC_TO_B] ? exc_sum[1:0]
                                                              : 2'h0;
    end else begin
      next_exc_a = {1'b0, current_source_control[sdac_pkg::CSC_SRC1]};
      next_exc_b = {1'b0, current_source_control[sdac_pkg::CSC_SRC2]};
    end
    // Software clear first so that a same-cycle set below wins
    next_rdy = rdy & ~ready_clear;
    if (decimation_write) begin
      next_dec_word = decimation_wdata;
    end
    case (state)
      sdac_pkg::SDAC_IDLE: begin
        next_cal_pend = 2'h0;
      end
      sdac_pkg::SDAC_CAL: begin
        next_cal_ref_bad = cal_ref_bad | (cal_pend & {2{ref_flag}});
        if (cal_pend == 2'h0) begin
          next_state = sdac_pkg::SDAC_IDLE;
          next_mode  = sdac_pkg::MODE_IDLE;
        end
      end
      default: begin
        next_state = sdac_pkg::SDAC_IDLE;
      end
    endcase
    if (push_valid && fifo_in_ready) begin
      next_pend[push_sel] = 1'b0;
    end
    for (int i = 0; i < 2; i++) begin
      if (restart[i]) begin
        next_seen[i] = 1'b0;
        next_chop[i] = 1'b0;
      end else if (f_valid[i]) begin
        next_chop[i] = ~chop[i];
        s_val = chop[i] ? -f_data[i] : f_data[i];
        sum   = {s_val[AW-1], s_val} + {prev[i][AW-1], prev[i]};
        raw   = sum[sdac_pkg::RAW_MSB+1 -: 16];
        next_prev[i] = s_val;
        next_seen[i] = 1'b1;
        if (seen[i]) begin
          if (state == sdac_pkg::SDAC_CAL && cal_pend[i]) begin
            next_cal_pend[i] = 1'b0;
            next_rdy[i] = 1'b1;
            if (cal_ref_bad[i] || ref_flag) begin
              next_err[i] = 1'b1;
            end else if (cal_kind[sdac_pkg::MODE_FULL_BIT]) begin
              next_gain_c[i] = raw;
            end else begin
              next_off_c[i] = raw;
            end
          end else if (state == sdac_pkg::SDAC_IDLE) begin
            next_res_q[i] = sdac_to_code(raw, off_c[i], gain_c[i],
                                         uni[i], ref_flag);
            next_pend_word[i] = next_res_q[i];
            next_pend[i] = 1'b1;
            next_rdy[i] = 1'b1;
          end
        end
      end
    end
    if (mode_write) begin
      next_mode    = mode_wdata;
      next_en_mask = enable_wdata;
      if (mode_wdata[sdac_pkg::MODE_CAL_BIT]) begin
        next_state       = sdac_pkg::SDAC_CAL;
        next_cal_kind    = mode_wdata;
        next_cal_pend    = enable_wdata;
        next_cal_ref_bad = 2'h0;
        next_err         = err & ~enable_wdata;
      end else begin
        next_state    = sdac_pkg::SDAC_IDLE;
        next_cal_pend = 2'h0;
      end
    end
    // Internal modes switch the reference points onto the modulator
    next_conn_zero = (next_state == sdac_pkg::SDAC_CAL) &&
                     (next_cal_kind == sdac_pkg::CAL_INT_ZERO);
    next_conn_full = (next_state == sdac_pkg::SDAC_CAL) &&
                     (next_cal_kind == sdac_pkg::CAL_INT_FULL);
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state       <= sdac_pkg::SDAC_IDLE;
      mode        <= sdac_pkg::MODE_RESET;
      en_mask     <= 2'h0;
      dec_word    <= sdac_pkg::DEC_RESET;
      cal_kind    <= sdac_pkg::MODE_RESET;
      cal_pend    <= 2'h0;
      cal_ref_bad <= 2'h0;
      rdy         <= 2'h0;
      err         <= 2'h0;
      ref_flag    <= 1'b0;
      conn_zero   <= 1'b0;
      conn_full   <= 1'b0;
      bo_on       <= 1'b0;
      exc_a       <= 2'h0;
      exc_b       <= 2'h0;
      chop        <= 2'h0;
      seen        <= 2'h0;
      pend        <= 2'h0;
      // Factory coefficients reload on every reset
      off_c[0]    <= factory_offset_primary;
      off_c[1]    <= factory_offset_aux;
      gain_c[0]   <= factory_gain_primary;
      gain_c[1]   <= factory_gain_aux;
      res_q       <= '{default: '0};
      pend_word   <= '{default: '0};
      prev        <= '{default: '0};
    end else begin
      state       <= next_state;
      mode        <= next_mode;
      en_mask     <= next_en_mask;
      dec_word    <= next_dec_word;
      cal_kind    <= next_cal_kind;
      cal_pend    <= next_cal_pend;
      cal_ref_bad <= next_cal_ref_bad;
      rdy         <= next_rdy;
      err         <= next_err;
      ref_flag    <= next_ref_flag;
      conn_zero   <= next_conn_zero;
      conn_full   <= next_conn_full;
      bo_on       <= next_bo_on;
      exc_a       <= next_exc_a;
      exc_b       <= next_exc_b;
      chop        <= next_chop;
      seen        <= next_seen;
      pend        <= next_pend;
      off_c       <= next_off_c;
      gain_c      <= next_gain_c;
      res_q       <= next_res_q;
      pend_word   <= next_pend_word;
      prev        <= next_prev;
    end
  end

  always_comb begin
    chop_invert              = chop;
    burnout_source_on        = bo_on;
    burnout_sink_on          = bo_on;
    excitation_out_a         = exc_a;
    excitation_out_b         = exc_b;
    ref_missing_flag         = ref_flag;
    adc_mode                 = mode;
    adc_enable               = en_mask;
    decimation_word          = dec_word;
    offset_primary           = off_c[0];
    offset_aux               = off_c[1];
    gain_primary             = gain_c[0];
    gain_aux                 = gain_c[1];
    cal_connect_zero         = conn_zero;
    cal_connect_full         = conn_full;
    conversion_ready_primary = rdy[0];
    conversion_ready_aux     = rdy[1];
    cal_error_primary        = err[0];
    cal_error_aux            = err[1];
    result_primary           = res_q[0];
    result_aux               = res_q[1];
  end
endmodule

// *** sdac_pkg.sv ***
package sdac_pkg;
  // Data path widths
  localparam int RES_W     = 16;
  localparam int ACC_W     = 35;
  localparam int RAT_W     = 11;
  localparam int RAW_MSB   = 33;
  localparam int FIFO_W    = 17;
  localparam int FIFO_DEPTH = 32;

  // Decimation word: reset value and the forced calibration value
  localparam logic [7:0] DEC_RESET = 8'h45;
  localparam logic [7:0] DEC_CAL   = 8'hFF;
  // Log2 of the modulator samples per decimation word step
  localparam int DEC_SHIFT = 3;

  // Mode field of the mode register
  localparam logic [2:0] MODE_IDLE     = 3'h1;
  localparam logic [2:0] MODE_CONT     = 3'h3;
  localparam logic [2:0] CAL_INT_ZERO  = 3'h4;
  localparam logic [2:0] CAL_INT_FULL  = 3'h5;
  localparam logic [2:0] CAL_SYS_ZERO  = 3'h6;
  localparam logic [2:0] CAL_SYS_FULL  = 3'h7;
  localparam logic [2:0] MODE_RESET    = MODE_IDLE;
  localparam int         MODE_CAL_BIT  = 2;
  localparam int         MODE_FULL_BIT = 0;

  // Current source control field positions
  localparam int CSC_SRC1    = 0;
  localparam int CSC_SRC2    = 1;
  localparam int CSC_COMBINE = 2;
  localparam int CSC_TO_B    = 3;

  // Result coding
  localparam logic [15:0] CODE_ALL_ONES = 16'hFFFF;
  localparam logic [15:0] CODE_ZERO     = 16'h0000;
  localparam logic [15:0] SAT_MAX       = 16'h7FFF;
  localparam logic [15:0] SAT_MIN       = 16'h8000;
  localparam int          GAIN_FRAC     = 15;

  localparam logic signed [ACC_W-1:0] ACC_ONE = 35'h000000001;

  typedef enum logic {SDAC_IDLE, SDAC_CAL} sdac_state_t;
endpackage

// *** sdac_fifo.sv ***
`timescale 1ns/10ps
module sdac_fifo #(
  parameter int WIDTH = sdac_pkg::FIFO_W,
  parameter int DEPTH = sdac_pkg::FIFO_DEPTH
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic [AW:0]      next_wr_ptr;
  logic [AW:0]      next_rd_ptr;
  logic             push;
  logic             pop;
  logic             full;
  logic             empty;

  always_comb begin
    empty     = (wr_ptr == rd_ptr);
    full      = (wr_ptr[AW] != rd_ptr[AW]) &&
                (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    in_ready  = ~full;
    out_valid = ~empty;
    push      = in_valid & ~full;
    pop       = out_valid & out_ready;
    next_wr_ptr = wr_ptr + (AW+1)'(push);
    next_rd_ptr = rd_ptr + (AW+1)'(pop);
    out_data  = mem[rd_ptr[AW-1:0]];
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end
endmodule

// *** sdac_sinc3.sv ***
`timescale 1ns/10ps
module sdac_sinc3 (
  input  wire logic                           core_clk,
  input  wire logic                           rst,
  input  wire logic                           restart,
  input  wire logic                           sample_en,
  input  wire logic                           sample_bit,
  input  wire logic [sdac_pkg::RAT_W-1:0]     ratio,
  output logic                                out_valid,
  output logic signed [sdac_pkg::ACC_W-1:0]   out_data
);
  localparam int W = sdac_pkg::ACC_W;

  logic signed [W-1:0] int1, int2, int3;
  logic signed [W-1:0] dly1, dly2, dly3;
  logic signed [W-1:0] next_int1, next_int2, next_int3;
  logic signed [W-1:0] next_dly1, next_dly2, next_dly3;
  logic signed [W-1:0] next_out_data;
  logic signed [W-1:0] x, c1, c2, c3;
  logic [sdac_pkg::RAT_W-1:0] cnt, next_cnt;
  logic                        next_out_valid;

  // Integrators wrap freely; the combs undo the wrap exactly
  always_comb begin
    x  = sample_bit ? sdac_pkg::ACC_ONE : -sdac_pkg::ACC_ONE;
    c1 = int3 - dly1;
    c2 = c1 - dly2;
    c3 = c2 - dly3;
    next_int1 = int1;
    next_int2 = int2;
    next_int3 = int3;
    next_dly1 = dly1;
    next_dly2 = dly2;
    next_dly3 = dly3;
    next_cnt  = cnt;
    next_out_data  = out_data;
    next_out_valid = 1'b0;
    if (restart) begin
      next_int1 = '0;
      next_int2 = '0;
      next_int3 = '0;
      next_dly1 = '0;
      next_dly2 = '0;
      next_dly3 = '0;
      next_cnt  = '0;
    end else if (sample_en) begin
      next_int1 = int1 + x;
      next_int2 = int2 + int1;
      next_int3 = int3 + int2;
      if (cnt >= ratio - 1'b1) begin
        next_cnt  = '0;
        next_dly1 = int3;
        next_dly2 = c1;
        next_dly3 = c2;
        next_out_data  = c3;
        next_out_valid = 1'b1;
      end else begin
        next_cnt = cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      int1 <= '0;
      int2 <= '0;
      int3 <= '0;
      dly1 <= '0;
      dly2 <= '0;
      dly3 <= '0;
      cnt  <= '0;
      out_data  <= '0;
      out_valid <= 1'b0;
    end else begin
      int1 <= next_int1;
      int2 <= next_int2;
      int3 <= next_int3;
      dly1 <= next_dly1;
      dly2 <= next_dly2;
      dly3 <= next_dly3;
      cnt  <= next_cnt;
      out_data  <= next_out_data;
      out_valid <= next_out_valid;
    end
  end
endmodule

// *** sdac_monitor.sv ***
`timescale 1ns/10ps
module sdac_monitor (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        burnout_enable,
  input wire logic        burnout_source_on,
  input wire logic        burnout_sink_on,
  input wire logic        ref_detect_low,
  input wire logic        ref_missing_flag,
  input wire logic        mode_write,
  input wire logic [2:0]  mode_wdata,
  input wire logic [1:0]  enable_wdata,
  input wire logic [2:0]  adc_mode,
  input wire logic [1:0]  adc_enable,
  input wire logic [7:0]  decimation_word,
  input wire logic [15:0] offset_primary,
  input wire logic [15:0] gain_primary,
  input wire logic        cal_connect_zero,
  input wire logic        cal_connect_full,
  input wire logic        cal_error_primary,
  input wire logic        mod_hold,
  input wire logic [15:0] result_primary
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  chk_burnout_pair: assert property (burnout_source_on == burnout_sink_on)
    else $error("burnout currents differ");
  chk_burnout_off: assert property (!burnout_enable |=> !burnout_sink_on)
    else $error("burnout left on");
  chk_ref_flag: assert property (ref_detect_low |=> ref_missing_flag)
    else $error("reference flag missing");
  chk_result_ones: assert property ($changed(result_primary)
    && $past(ref_missing_flag) |-> result_primary == 16'hFFFF)
    else $error("result not all ones");
  chk_dec_reset: assert property ($fell(rst) |-> decimation_word == 8'h45)
    else $error("decimation reset value");
  chk_zero_conn: assert property (mode_write && mode_wdata == 3'h4
    |=> cal_connect_zero && !cal_connect_full)
    else $error("zero source not connected");
  chk_full_conn: assert property (mode_write && mode_wdata == 3'h5
    |=> cal_connect_full && !cal_connect_zero)
    else $error("full source not connected");
  chk_err_clear: assert property (mode_write && mode_wdata[2]
    && enable_wdata[0] |=> !cal_error_primary)
    else $error("cal error not cleared");
  chk_offset_keep: assert property (adc_mode[0] && adc_mode[2]
    |=> $stable(offset_primary))
    else $error("offset changed in full scale");
  chk_enable_keep: assert property (!adc_enable[0] |=>
    $stable(offset_primary) && $stable(gain_primary))
    else $error("disabled coefficients changed");
  cov_err: cover property ($rose(cal_error_primary));
  cov_full: cover property ($rose(mod_hold));
  cov_fcal: cover property ($rose(cal_connect_full));
endmodule
bind sdac_backend sdac_monitor i_mon (.*);

// *** sdac_mod_src.sv ***
`timescale 1ns/10ps
module sdac_mod_src (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       run,
  input  wire logic       high_level,
  input  wire logic [1:0] chop_invert,
  output logic      [1:0] mod_bit,
  output logic      [1:0] mod_valid
);
  logic [1:0] phase;
  logic [1:0] next_phase;
  always_comb begin
    next_phase = phase + 2'h1;
  end
  always_ff @(posedge core_clk) begin
    if (rst) phase <= 2'h0;
    else phase <= next_phase;
  end
  // Outside zero or full scale level is set before a system calibration
  // Reversed inputs follow the chop state, as the analog side would
  assign mod_bit   = {2{high_level ? phase != 2'h0 : phase[0]}}
                     ^ chop_invert;
  assign mod_valid = {2{run}};
endmodule

// *** sdac_backend_tb.sv ***
`timescale 1ns/10ps
module sdac_backend_tb;
  logic core_clk, rst, mod_hold, burnout_enable, burnout_source_on;
  logic burnout_sink_on, ref_detect_low, ref_missing_flag, mode_write;
  logic decimation_write, unipolar_primary, unipolar_aux, result_ready;
  logic cal_connect_zero, cal_connect_full, conversion_ready_primary;
  logic conversion_ready_aux, cal_error_primary, cal_error_aux;
  logic result_valid, run, high_level;
  logic [1:0] mod_bit, mod_valid, chop_invert, input_change, adc_enable;
  logic [1:0] excitation_out_a, excitation_out_b, enable_wdata, ready_clear;
  logic [2:0] mode_wdata, adc_mode;
  logic [3:0] current_source_control;
  logic [7:0] decimation_wdata, decimation_word;
  logic [15:0] factory_offset_primary, factory_offset_aux, off0;
  logic [15:0] factory_gain_primary, factory_gain_aux, gain0;
  logic [15:0] offset_primary, offset_aux, gain_primary, gain_aux;
  logic [15:0] result_primary, result_aux;
  logic [16:0] result_data;
  logic [3:0] csc [4] = '{4'h3, 4'h7, 4'hF, 4'h1};
  logic [3:0] exc [4] = '{4'h5, 4'h8, 4'h2, 4'h4};
  int mismatches, n_compared, i, m, n;
  sdac_backend i_dut (.*);
  sdac_mod_src i_src (.*);
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  task automatic chk(input string nm, input logic [16:0] e, g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic set_mode(input logic [2:0] md, input logic [1:0] en);
    ready_clear = 2'h3;
    @(negedge core_clk) ready_clear = 2'h0;
    mode_wdata = md;
    enable_wdata = en;
    mode_write = 1'b1;
    @(negedge core_clk) mode_write = 1'b0;
  endtask
  task automatic wait_rdy;
    n = 0;
    while (!(conversion_ready_primary | conversion_ready_aux) && n < 20000)
    begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 20000) mismatches++;
  endtask
  task automatic test_done;
    if (mismatches == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    {rst, burnout_enable, ref_detect_low, mode_write, run} = 5'h10;
    {decimation_write, unipolar_primary, unipolar_aux, high_level} = 4'h0;
    {input_change, ready_clear, enable_wdata, mode_wdata} = 9'h0;
    {result_ready, current_source_control, decimation_wdata} = 13'h0;
    factory_offset_primary = 16'h1234;
    factory_offset_aux = 16'h2345;
    factory_gain_primary = 16'h5A5A;
    factory_gain_aux = 16'h6B6B;
    repeat (3) @(negedge core_clk);
    rst = 1'b0;
    @(negedge core_clk);
    chk("decimation", 17'h45, 17'(decimation_word));
    chk("offset", 17'h1234, 17'(offset_primary));
    chk("gain aux", 17'h6B6B, 17'(gain_aux));
    burnout_enable = 1'b1;
    repeat (2) @(negedge core_clk);
    chk("burnout", 17'h3, 17'({burnout_source_on, burnout_sink_on}));
    burnout_enable = 1'b0;
    repeat (2) @(negedge core_clk);
    chk("burnout", 17'h0, 17'({burnout_source_on, burnout_sink_on}));
    for (i = 0; i < 4; i++) begin
      current_source_control = csc[i];
      repeat (2) @(negedge core_clk);
      chk("excite", 17'(exc[i]), 17'({excitation_out_a, excitation_out_b}));
    end
    run = 1'b1;
    ref_detect_low = 1'b1;
    set_mode(3'h4, 2'h1);
    wait_rdy;
    chk("cal error", 17'h1, 17'(cal_error_primary));
    chk("offset", 17'h1234, 17'(offset_primary));
    ref_detect_low = 1'b0;
    // Short word: calibration must still take the long count
    decimation_wdata = 8'h0D;
    decimation_write = 1'b1;
    @(negedge core_clk) decimation_write = 1'b0;
    for (m = 4; m < 8; m++) begin
      high_level = m[0];
      off0 = offset_primary;
      gain0 = gain_primary;
      set_mode(m[2:0], 2'h1);
      chk("cal error", 17'h0, 17'(cal_error_primary));
      chk("connect", 17'({!m[1] & m[0], !m[1] & !m[0]}),
          17'({cal_connect_full, cal_connect_zero}));
      wait_rdy;
      chk("cal span", 17'h1, 17'(n > 4000));
      chk("ready", 17'h1, 17'(conversion_ready_primary));
      chk("kept", 17'(m[0] ? off0 : gain0),
          17'(m[0] ? offset_primary : gain_primary));
      chk("loaded", 17'h1, 17'(m[0] ? gain_primary !== 16'h5A5A
                                   : offset_primary !== 16'h1234));
    end
    off0 = offset_primary;
    set_mode(3'h4, 2'h2);
    wait_rdy;
    chk("offset", 17'(off0), 17'(offset_primary));
    chk("ready aux", 17'h1, 17'(conversion_ready_aux));
    ref_detect_low = 1'b1;
    set_mode(3'h3, 2'h1);
    n = 0;
    while (mod_hold !== 1'b1 && n < 20000) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 20000) mismatches++;
    chk("result", 17'hFFFF, 17'(result_primary));
    run = 1'b0;
    set_mode(3'h1, 2'h0);
    result_ready = 1'b1;
    n = 0;
    while (result_valid === 1'b1 && n < 40) begin
      chk("word", 17'h0FFFF, result_data);
      @(negedge core_clk);
      n++;
    end
    chk("words", 17'd32, 17'(n));
    test_done;
  end
  initial begin
    repeat (60000) @(posedge core_clk);
    mismatches++;
    test_done;
  end
endmodule
